// >>> core/irc_regs.svh
`ifndef IRC_REGS_SVH
`define IRC_REGS_SVH

`define IRC_NSRC 12
`define IRC_NPIN 4
`define IRC_ADDR_REQ_LO 16'hFFE0
`define IRC_ADDR_REQ_HI 16'hFFE1
`define IRC_ADDR_MSK_LO 16'hFFE4
`define IRC_ADDR_MSK_HI 16'hFFE5
`define IRC_ADDR_EDG_LO 16'hFFEC
`define IRC_ADDR_EDG_HI 16'hFFED
`define IRC_REQ_RST 12'h000
`define IRC_MSK_RST 12'hFFF
`define IRC_EDG_RST 8'h00
`define IRC_HI_FILL_MSK 4'hF
`define IRC_HI_FILL_REQ 4'h0
`define IRC_VEC_NMI 16'h0004
`define IRC_VEC_BASE 16'h0004
`define IRC_IDX_WDT 4'h0
`define IRC_IDX_PIN0 4'h1
`define IRC_IDX_ERR 4'h5
`define IRC_IDX_RX 4'h6
`define IRC_IDX_TX 4'h7
`define IRC_IDX_T8A 4'h8
`define IRC_IDX_T8B 4'h9
`define IRC_IDX_T16A 4'hA
`define IRC_IDX_T16B 4'hB

`endif

// >>> core/irc_pkg.sv
package irc_pkg;
  typedef enum logic [1:0] {
    IRC_EDGE_FALL = 2'b00,
    IRC_EDGE_RISE = 2'b01,
    IRC_EDGE_BAD = 2'b10,
    IRC_EDGE_BOTH = 2'b11
  } irc_edge_t;
  typedef logic [3:0] irc_idx_t;
  typedef logic [11:0] irc_src_t;
endpackage

// >>> core/irc_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface irc_edge_if;
  import irc_pkg::*;
  logic pin;
  irc_edge_t code;
  logic hit;
  modport det (input pin, input code, output hit);
  modport ctl (output pin, output code, input hit);
endinterface
`default_nettype wire

// >>> core/irc_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module irc_edge_det
  import irc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  irc_edge_if.det port
);
  logic prev_r, prev_nxt;
  logic armed_r, armed_nxt;

  // no detection on the first cycle: the pin level at reset is unknown history
  always_comb begin
    prev_nxt = port.pin;
    armed_nxt = 1'b1;
    port.hit = 1'b0;
    if (armed_r) begin
      unique case (port.code)
        IRC_EDGE_FALL: port.hit = prev_r & ~port.pin;
        IRC_EDGE_RISE: port.hit = ~prev_r & port.pin;
        IRC_EDGE_BOTH: port.hit = prev_r ^ port.pin;
        IRC_EDGE_BAD: port.hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      armed_r <= armed_nxt;
    end
  end
endmodule // irc_edge_det
`default_nettype wire

// >>> core/irc_ctrl.sv
// Functional notes
// - watchdog non-maskable request ignores masks, wins
// - every unmasked request raises the standby wake-up
// - mask flags gate four external, eight internal
// - thirteen sources, watchdog counted twice
// - fixed default order, index 0 highest
// - watchdog overflow to one path; NMI vector 0004H
// - external request on selected pin edge
// - timer16 request: match or opposite-pin capture edge
// - flag set by event/write, cleared ack/reset/write
// - flag registers take bit and byte writes
// - reset clears both flag registers
// - flag bit layout; high register top nibble zero
// - one flag and one mask per source
// - flag zero means nothing pending
// - flag one means request pending
// - mask one blocks; reset masks all ones
// - two-bit edge code per pin, 10 prohibited
// - serve only flag, unmasked, global enable
`timescale 1ns/1ps
`default_nettype none
`include "irc_regs.svh"
module irc_ctrl
  import irc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_wbits,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata_r,
  input wire logic wdt_overflow,
  input wire logic wdt_nmi_mode,
  input wire logic [3:0] ext_pin,
  input wire logic uart_rx_error_irq,
  input wire logic uart_rx_done_irq,
  input wire logic uart_tx_done_irq,
  input wire logic timer8_a_match_irq,
  input wire logic timer8_b_match_irq,
  input wire logic timer16_a_match,
  input wire logic timer16_b_match,
  input wire logic timer16_a_capture_mode,
  input wire logic timer16_b_capture_mode,
  input wire logic timer16_input_a_edge,
  input wire logic timer16_input_b_edge,
  input wire logic global_irq_enable,
  input wire logic cpu_ack,
  input wire logic cpu_ack_nmi,
  output logic irq_req_r,
  output logic nmi_req_r,
  output logic [15:0] irq_vec_r,
  output logic wakeup_r
);
  irc_src_t flags_r, flags_nxt;
  irc_src_t mask_r, mask_nxt;
  logic [7:0] edge_r, edge_nxt;
  irc_idx_t sel_r, sel_nxt;
  logic irq_req_nxt, nmi_nxt, wake_nxt;
  logic [15:0] vec_nxt;
  logic [7:0] rdata_nxt;
  irc_src_t events, elig, ack_clr;
  logic [3:0] pin_hit;
  irc_idx_t win;
  logic wr_req_lo, wr_req_hi;
  logic [7:0] req_hi_m, msk_hi_m;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
                                       input logic [7:0] bits);
    merge = (old & ~bits) | (d & bits);
  endfunction

  // lowest index wins; scan from the top index down so the last hit is the best
  function automatic irc_idx_t first_set(input irc_src_t v);
    first_set = '0;
    for (int i = `IRC_NSRC - 1; i >= 0; i--) begin
      if (v[i]) first_set = irc_idx_t'(i);
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `IRC_NPIN; g++) begin : g_pin
      irc_edge_if eif ();
      assign eif.pin = ext_pin[g];
      assign eif.code = irc_edge_t'(edge_r[2*g+1:2*g]);
      assign pin_hit[g] = eif.hit;
      irc_edge_det u_det (.clk(clk), .rst_n(rst_n), .port(eif.det));
    end
  endgenerate

  assign wr_req_lo = bus_wr && (bus_addr == `IRC_ADDR_REQ_LO);
  assign wr_req_hi = bus_wr && (bus_addr == `IRC_ADDR_REQ_HI);

  // one flag per source, in default-order index
  always_comb begin
    events = '0;
    events[`IRC_IDX_WDT] = wdt_overflow && !wdt_nmi_mode;
    events[`IRC_IDX_PIN0 +: `IRC_NPIN] = pin_hit;
    events[`IRC_IDX_ERR] = uart_rx_error_irq;
    events[`IRC_IDX_RX] = uart_rx_done_irq;
    events[`IRC_IDX_TX] = uart_tx_done_irq;
    events[`IRC_IDX_T8A] = timer8_a_match_irq;
    events[`IRC_IDX_T8B] = timer8_b_match_irq;
    // capture mode takes the opposite input's valid edge
    events[`IRC_IDX_T16A] = timer16_a_capture_mode ? timer16_input_b_edge
                                                   : timer16_a_match;
    events[`IRC_IDX_T16B] = timer16_b_capture_mode ? timer16_input_a_edge
                                                   : timer16_b_match;
  end

  always_comb begin
    ack_clr = '0;
    if (cpu_ack && irq_req_r) ack_clr[sel_r] = 1'b1;
    flags_nxt = flags_r & ~ack_clr;
    req_hi_m = merge({`IRC_HI_FILL_REQ, flags_nxt[11:8]}, bus_wdata, bus_wbits);
    msk_hi_m = merge({`IRC_HI_FILL_MSK, mask_r[11:8]}, bus_wdata, bus_wbits);
    if (wr_req_lo) flags_nxt[7:0] = merge(flags_nxt[7:0], bus_wdata, bus_wbits);
    // only the low nibble exists; the fill bits never reach a flag
    if (wr_req_hi) flags_nxt[11:8] = req_hi_m[3:0];
    // a source event wins over any clear in the same cycle
    flags_nxt = flags_nxt | events;
    mask_nxt = mask_r;
    if (bus_wr && bus_addr == `IRC_ADDR_MSK_LO) mask_nxt[7:0] = merge(mask_r[7:0], bus_wdata,
                                                                      bus_wbits);
    if (bus_wr && bus_addr == `IRC_ADDR_MSK_HI) mask_nxt[11:8] = msk_hi_m[3:0];
    edge_nxt = edge_r;
    if (bus_wr && bus_addr == `IRC_ADDR_EDG_LO) edge_nxt[5:0] = bus_wdata[7:2];
    if (bus_wr && bus_addr == `IRC_ADDR_EDG_HI) edge_nxt[7:6] = bus_wdata[1:0];
  end

  // arbitration runs every clock on live flags
  always_comb begin
    elig = flags_r & ~mask_r;
    win = first_set(elig);
    nmi_nxt = (nmi_req_r && !cpu_ack_nmi) || (wdt_overflow && wdt_nmi_mode);
    irq_req_nxt = global_irq_enable && (|elig);
    sel_nxt = irq_req_nxt ? win : sel_r;
    if (nmi_req_r) vec_nxt = `IRC_VEC_NMI;
    else vec_nxt = `IRC_VEC_BASE + {11'h000, win, 1'b0};
    wake_nxt = nmi_req_r || (|elig);
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (bus_rd) begin
      unique case (bus_addr)
        `IRC_ADDR_REQ_LO: rdata_nxt = flags_r[7:0];
        `IRC_ADDR_REQ_HI: rdata_nxt = {`IRC_HI_FILL_REQ, flags_r[11:8]};
        `IRC_ADDR_MSK_LO: rdata_nxt = mask_r[7:0];
        `IRC_ADDR_MSK_HI: rdata_nxt = {`IRC_HI_FILL_MSK, mask_r[11:8]};
        `IRC_ADDR_EDG_LO: rdata_nxt = {edge_r[5:0], 2'b00};
        `IRC_ADDR_EDG_HI: rdata_nxt = {6'h00, edge_r[7:6]};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= `IRC_REQ_RST;
      mask_r <= `IRC_MSK_RST;
      edge_r <= `IRC_EDG_RST;
      sel_r <= '0;
      irq_req_r <= 1'b0;
      nmi_req_r <= 1'b0;
      irq_vec_r <= 16'h0000;
      wakeup_r <= 1'b0;
      bus_rdata_r <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
      mask_r <= mask_nxt;
      edge_r <= edge_nxt;
      sel_r <= sel_nxt;
      irq_req_r <= irq_req_nxt;
      nmi_req_r <= nmi_nxt;
      irq_vec_r <= vec_nxt;
      wakeup_r <= wake_nxt;
      bus_rdata_r <= rdata_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_nmi_always: assert property (
    wdt_overflow && wdt_nmi_mode |=> nmi_req_r)
    else $error("nmi request not raised");
  chk_nmi_route_only: assert property (
    wdt_overflow && wdt_nmi_mode && !wr_req_lo && !flags_r[0] |=> !flags_r[0])
    else $error("watchdog flag set in nmi mode");
  chk_nmi_vector: assert property (
    nmi_req_r |=> irq_vec_r == `IRC_VEC_NMI)
    else $error("nmi vector wrong");
  chk_wake_follow: assert property (
    (|(flags_r & ~mask_r)) || nmi_req_r |=> wakeup_r)
    else $error("wake-up missing");
  chk_enable_gate: assert property (
    irq_req_r |-> $past(global_irq_enable) && $past(|(flags_r & ~mask_r)))
    else $error("request without enable");
  chk_prio_order: assert property (
    irq_req_r && !$past(nmi_req_r) |->
      irq_vec_r == `IRC_VEC_BASE + {11'h000, first_set($past(elig)), 1'b0})
    else $error("wrong winner");
  chk_pin_edge_set: assert property (
    pin_hit[0] |=> flags_r[1])
    else $error("pin flag not set");
  chk_ack_clear: assert property (
    cpu_ack && irq_req_r && !events[sel_r] && !wr_req_lo && !wr_req_hi
      |=> !flags_r[$past(sel_r)])
    else $error("ack did not clear flag");
  chk_pend_hold: assert property (
    flags_r[3] && !wr_req_lo && !(cpu_ack && irq_req_r && sel_r == 4'h3) |=> flags_r[3])
    else $error("pending flag lost");
  chk_hi_read_zero: assert property (
    bus_rd && bus_addr == `IRC_ADDR_REQ_HI |=> bus_rdata_r[7:4] == 4'h0)
    else $error("high flag nibble not zero");

  cov_nmi_taken: cover property (nmi_req_r ##1 cpu_ack_nmi);
  cov_mask_ack: cover property (irq_req_r && cpu_ack);
  cov_two_pending: cover property ($countones(elig) > 1 && global_irq_enable);
endmodule // irc_ctrl
`default_nettype wire

// >>> verif/irc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module irc_cpu_model (
  input wire logic clk,
  input wire logic en,
  input wire logic irq_req_r,
  input wire logic nmi_req_r,
  input wire logic [15:0] irq_vec_r,
  input wire logic wakeup_r,
  output var logic cpu_ack,
  output var logic cpu_ack_nmi,
  output logic global_irq_enable,
  output var logic took,
  output var logic [15:0] vec,
  output var logic wk
);
  logic busy = 1'b0;
  // taking a request drops the enable until the handler returns
  assign global_irq_enable = en && !busy;
  initial begin
    {cpu_ack, cpu_ack_nmi, took, wk, vec} = '0;
    forever begin
      @(posedge clk);
      if (nmi_req_r || irq_req_r) begin
        // prompt or slow, like a short or long instruction in flight
        repeat ($urandom_range(4, 1)) @(posedge clk);
        #1 {cpu_ack_nmi, cpu_ack} = {nmi_req_r, !nmi_req_r};
        @(posedge clk);
        {vec, wk} = {irq_vec_r, wakeup_r};
        #1 {cpu_ack, cpu_ack_nmi, took, busy} = 4'b0011;
        @(posedge clk);
        #1 took = 1'b0;
        repeat ($urandom_range(5, 2)) @(posedge clk);
        #1 busy = 1'b0;
      end
    end
  end
endmodule // irc_cpu_model
`default_nettype wire

// >>> verif/interrupt_request_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module interrupt_request_controller_bench;
  logic clk = 1'b0, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, rd_d = 1'b0;
  logic nmi_mode = 1'b0, cap_a = 1'b0, cap_b = 1'b0, en = 1'b0;
  logic [15:0] bus_addr = '0;
  logic [7:0] bus_wdata = '0, bus_wbits = '0, bus_rdata_r, r, er;
  logic [9:0] evt = '0;
  logic [3:0] ext_pin = 4'hF;
  logic irq_req_r, nmi_req_r, wakeup_r, cpu_ack, cpu_ack_nmi, ie, took, wk;
  logic [15:0] irq_vec_r, vec, ev;
  logic [7:0] rd_q[$];
  logic [15:0] vec_q[$];
  int fail_count = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  irc_ctrl irc_ctrl_inst (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_wbits(bus_wbits), .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r),
    .wdt_overflow(evt[0]), .wdt_nmi_mode(nmi_mode), .ext_pin(ext_pin),
    .uart_rx_error_irq(evt[1]), .uart_rx_done_irq(evt[2]), .uart_tx_done_irq(evt[3]),
    .timer8_a_match_irq(evt[4]), .timer8_b_match_irq(evt[5]), .timer16_a_match(evt[6]),
    .timer16_b_match(evt[7]), .timer16_a_capture_mode(cap_a), .timer16_b_capture_mode(cap_b),
    .timer16_input_a_edge(evt[8]), .timer16_input_b_edge(evt[9]), .global_irq_enable(ie),
    .cpu_ack(cpu_ack), .cpu_ack_nmi(cpu_ack_nmi), .irq_req_r(irq_req_r),
    .nmi_req_r(nmi_req_r), .irq_vec_r(irq_vec_r), .wakeup_r(wakeup_r));
  irc_cpu_model irc_cpu_model_inst (.clk(clk), .en(en), .irq_req_r(irq_req_r),
    .nmi_req_r(nmi_req_r), .irq_vec_r(irq_vec_r), .wakeup_r(wakeup_r), .cpu_ack(cpu_ack),
    .cpu_ack_nmi(cpu_ack_nmi), .global_irq_enable(ie), .took(took), .vec(vec), .wk(wk));
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    {bus_addr, bus_wdata, bus_wbits, bus_wr} = {a, d, m, 1'b1};
    @(posedge clk);
    #1 bus_wr = 1'b0;
    // idle edge so the next strobe is not raised in the step it fell
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    {bus_addr, bus_rd} = {a, 1'b1};
    rd_q.push_back(e);
    @(posedge clk);
    #1 bus_rd = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int k);
    evt[k] = 1'b1;
    @(posedge clk);
    #1 evt[k] = 1'b0;
  endtask
  // extra edges catch an acknowledge that nobody expected
  task automatic drain();
    for (int n = 0; n < 300 && vec_q.size() > 0; n++) @(posedge clk);
    repeat (12) @(posedge clk);
    #1;
    `CHK("pending", 0, vec_q.size())
  endtask
  task automatic finish_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    rd_d <= bus_rd;
    if (rd_d) begin
      er = rd_q.size() ? rd_q.pop_front() : 'x;
      `CHK("rdata", er, bus_rdata_r)
    end
    if (took) begin
      ev = vec_q.size() ? vec_q.pop_front() : 'x;
      `CHK("vector", ev, vec)
      `CHK("wakeup", 1'b1, wk)
    end
  end
  initial begin
    #(25 * 8000);
    fail_count++;
    finish_test();
  end
  initial begin
    r = 8'($urandom(32'h8dae));
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
    rd(16'hFFE0, 8'h00);
    rd(16'hFFE1, 8'h00);
    rd(16'hFFE4, 8'hFF);
    rd(16'hFFE5, 8'hFF);
    rd(16'hFFEC, 8'h00);
    rd(16'hFFD2, 8'h00);
    r = 8'($urandom);
    wr(16'hFFE4, r, 8'hFF);
    rd(16'hFFE4, r);
    wr(16'hFFE0, 8'h40, 8'h40);
    rd(16'hFFE0, 8'h40);
    wr(16'hFFE0, 8'h00, 8'h40);
    rd(16'hFFE0, 8'h00);
    wr(16'hFFE4, 8'h00, 8'hFF);
    wr(16'hFFE5, 8'h00, 8'hFF);
    wr(16'hFFE0, 8'hE0, 8'hFF);
    wr(16'hFFE1, 8'hFF, 8'hFF);
    rd(16'hFFE1, 8'h0F);
    rd(16'hFFE5, 8'hF0);
    for (int i = 5; i < 12; i++) vec_q.push_back(16'(4 + 2 * i));
    en = 1'b1;
    drain();
    for (int i = 5; i < 12; i++) begin
      vec_q.push_back(16'(4 + 2 * i));
      pulse(i - 4);
      drain();
    end
    {cap_a, cap_b} = 2'b11;
    pulse(6);
    drain();
    vec_q.push_back(16'h0018);
    pulse(9);
    drain();
    vec_q.push_back(16'h001A);
    pulse(8);
    drain();
    wr(16'hFFEC, 8'hD0, 8'hFF);
    wr(16'hFFED, 8'h02, 8'hFF);
    vec_q = {16'h0006, 16'h000A};
    ext_pin = 4'h0;
    drain();
    vec_q = {16'h0008, 16'h000A};
    ext_pin = 4'hF;
    drain();
    {en, nmi_mode} = 2'b01;
    wr(16'hFFE4, 8'h01, 8'h01);
    vec_q.push_back(16'h0004);
    pulse(0);
    drain();
    rd(16'hFFE0, 8'h00);
    {en, nmi_mode} = 2'b10;
    wr(16'hFFE4, 8'h00, 8'h01);
    vec_q.push_back(16'h0004);
    pulse(0);
    drain();
    wr(16'hFFE4, 8'hFF, 8'hFF);
    pulse(2);
    drain();
    rd(16'hFFE0, 8'h40);
    vec_q.push_back(16'h0010);
    wr(16'hFFE4, 8'hBF, 8'hFF);
    drain();
    finish_test();
  end
endmodule // interrupt_request_controller_bench
`default_nettype wire
